// ---- core/suspend_params.svh ----
// Constants for the flash suspend and resume control
`ifndef SUSPEND_PARAMS_SVH
`define SUSPEND_PARAMS_SVH
`define CLK_PERIOD_NS 100
`define OP_ERASE_SUSPEND 8'h75
`define OP_ERASE_RESUME 8'h7A
`define OP_PROG_SUSPEND 8'h85
`define OP_PROG_RESUME 8'h8A
`define OP_READ_STATUS 8'h05
`define OP_PROG 8'h02
`define OP_ERASE 8'hD8
`define OP_READ 8'h03
`define OP_READ_PARAM 8'h5A
`define SUSPEND_PARAM_WORD 32'h4418_83EC
`define SUSPEND_LAT_NS 40000
`define SUSPEND_LAT_CYC (`SUSPEND_LAT_NS / `CLK_PERIOD_NS)
`define RESUME_GAP_NS 128000
`define RESUME_GAP_CYC ((`RESUME_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUSPEND_WORK_CYC 16
`define WIP_BIT 0
`endif

// ---- core/suspend_pkg.sv ----
// Types shared by both ends of the suspend control link
package suspend_pkg;
  typedef logic [7:0] opcode_type;
  typedef logic [23:0] addr_type;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_ERASE = 3'b001,
    ST_PROG = 3'b010,
    ST_ERASE_SUSP = 3'b011,
    ST_PROG_SUSP = 3'b100
  } flash_state_type;
endpackage

// ---- core/suspend_if.sv ----
// Instruction link between host controller and flash device
`timescale 1ns/10ps
interface suspend_if (input wire logic clock);
  import suspend_pkg::*;
  logic cmdValid;
  opcode_type cmdOpcode;
  addr_type cmdAddr;
  logic rspValid;
  logic [31:0] rspData;
  modport device (input clock, cmdValid, cmdOpcode, cmdAddr, output rspValid, rspData);
  modport host (input clock, rspValid, rspData, output cmdValid, cmdOpcode, cmdAddr);
endinterface

// ---- core/flash_suspend_device.sv ----
// Flash device end: program, erase, suspend and resume sequencing
// Summary of operation
// (RULE1) Erase suspend takes effect within 40 us
// (RULE2) Host waits 128 us before re-suspending erase
// (RULE3) Program suspend takes effect within 40 us
// (RULE4) Host waits 128 us before re-suspending program
// (RULE5) No new erase during erase suspend
// (RULE6) No program to erase-suspended sector
// (RULE7) No read from erase-suspended sector
// (RULE8) No erase during program suspend
// (RULE9) No program during program suspend
// (RULE10) Erase suspend instruction is 75h
// (RULE11) Erase resume instruction is 7Ah
// (RULE12) Program suspend instruction is 85h
// (RULE13) Program resume instruction is 8Ah
// (RULE14) Suspend parameter word reads 44_18_83_EC
// (RULE15) Status read 05h shows busy in bit 0
// (RULE16) Ignore suspend or resume without matching state
// (RULE17) Resume sets busy until done or suspended
`timescale 1ns/10ps
`include "suspend_params.svh"
module flash_suspend_device
#(
  parameter int ERASE_CYC = 20000,
  parameter int PROG_CYC = 5000
)
(
  suspend_if.device link,
  input wire logic rst_n,
  output suspend_pkg::flash_state_type state,
  output logic busy
);
  import suspend_pkg::*;
  flash_state_type state_r;
  logic [31:0] eraseCnt_r;
  logic [31:0] progCnt_r;
  logic eraseHeld_r;
  logic [15:0] suspCnt_r;
  logic suspPend_r;
  logic rspValid_r;
  logic [31:0] rspData_r;
  // Operation and suspend sequencing
  always_ff @(posedge link.clock)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      eraseCnt_r <= 32'h0000_0000;
      progCnt_r <= 32'h0000_0000;
      eraseHeld_r <= 1'b0;
      suspCnt_r <= 16'h0000;
      suspPend_r <= 1'b0;
    end
    else
    begin
      if (suspPend_r)
      begin
        // Suspend completes after a fixed short wind-down, well inside the limit
        if (suspCnt_r >= 16'(`SUSPEND_WORK_CYC))
        begin
          suspPend_r <= 1'b0; // RULE1 RULE3
          state_r <= (state_r == ST_ERASE) ? ST_ERASE_SUSP : ST_PROG_SUSP;
        end
        else
          suspCnt_r <= suspCnt_r + 16'h0001;
      end
      else if (state_r == ST_ERASE)
      begin
        if (eraseCnt_r + 32'h0000_0001 >= 32'(ERASE_CYC))
          state_r <= ST_IDLE;
        else
          eraseCnt_r <= eraseCnt_r + 32'h0000_0001;
      end
      else if (state_r == ST_PROG)
      begin
        if (progCnt_r + 32'h0000_0001 >= 32'(PROG_CYC))
        begin
          // A program made inside an erase suspend hands back to the held erase
          state_r <= eraseHeld_r ? ST_ERASE_SUSP : ST_IDLE;
          eraseHeld_r <= 1'b0;
        end
        else
          progCnt_r <= progCnt_r + 32'h0000_0001;
      end
      if (link.cmdValid)
      begin
        case (link.cmdOpcode)
          `OP_ERASE_SUSPEND:
            if (state_r == ST_ERASE && !suspPend_r) // RULE10 RULE16
            begin
              suspPend_r <= 1'b1;
              suspCnt_r <= 16'h0000;
            end
          `OP_PROG_SUSPEND:
            if (state_r == ST_PROG && !suspPend_r) // RULE12 RULE16
            begin
              suspPend_r <= 1'b1;
              suspCnt_r <= 16'h0000;
            end
          `OP_ERASE_RESUME:
            if (state_r == ST_ERASE_SUSP)
              state_r <= ST_ERASE; // RULE11 RULE16 RULE17
          `OP_PROG_RESUME:
            if (state_r == ST_PROG_SUSP)
              state_r <= ST_PROG; // RULE13 RULE16 RULE17
          `OP_ERASE:
            if (state_r == ST_IDLE)
            begin
              state_r <= ST_ERASE;
              eraseCnt_r <= 32'h0000_0000;
            end
          `OP_PROG:
            if (state_r == ST_IDLE || state_r == ST_ERASE_SUSP)
            begin
              state_r <= ST_PROG;
              progCnt_r <= 32'h0000_0000;
              eraseHeld_r <= (state_r == ST_ERASE_SUSP);
            end
          default:
            ;
        endcase
      end
    end
  end
  // Read answers: status and parameter word
  always_ff @(posedge link.clock)
  begin
    if (!rst_n)
    begin
      rspValid_r <= 1'b0;
      rspData_r <= 32'h0000_0000;
    end
    else
    begin
      rspValid_r <= 1'b0;
      if (link.cmdValid && link.cmdOpcode == `OP_READ_STATUS)
      begin
        rspValid_r <= 1'b1;
        rspData_r <= 32'h0000_0000;
        rspData_r[`WIP_BIT] <= busy; // RULE15
      end
      else if (link.cmdValid && link.cmdOpcode == `OP_READ_PARAM)
      begin
        rspValid_r <= 1'b1;
        rspData_r <= `SUSPEND_PARAM_WORD; // RULE14
      end
    end
  end
  assign busy = (state_r == ST_ERASE) || (state_r == ST_PROG); // RULE17
  assign state = state_r;
  assign link.rspValid = rspValid_r;
  assign link.rspData = rspData_r;
endmodule // flash_suspend_device

// ---- core/flash_suspend_host.sv ----
// Host controller end: issues instructions and keeps suspend restrictions
`timescale 1ns/10ps
`include "suspend_params.svh"
module flash_suspend_host
(
  suspend_if.host link,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire suspend_pkg::opcode_type reqOpcode,
  input wire suspend_pkg::addr_type reqAddr,
  output logic reqReady,
  output logic [31:0] rdData,
  output logic rdValid
);
  import suspend_pkg::*;
  logic eraseSusp_r;
  logic progSusp_r;
  logic [15:0] sector_r;
  logic [31:0] eraseGap_r;
  logic [31:0] progGap_r;
  logic cmdValid_r;
  opcode_type cmdOpcode_r;
  addr_type cmdAddr_r;
  logic [31:0] rdData_r;
  logic rdValid_r;
  logic allowed;
  always_comb
  begin
    allowed = 1'b1;
    case (reqOpcode)
      `OP_ERASE:
        allowed = !eraseSusp_r && !progSusp_r; // RULE5 RULE8
      `OP_PROG:
        allowed = !progSusp_r && !(eraseSusp_r && reqAddr[23:8] == sector_r); // RULE6 RULE9
      `OP_READ:
        allowed = !(eraseSusp_r && reqAddr[23:8] == sector_r); // RULE7
      `OP_ERASE_SUSPEND:
        allowed = eraseGap_r == 32'h0000_0000; // RULE2
      `OP_PROG_SUSPEND:
        allowed = progGap_r == 32'h0000_0000; // RULE4
      default:
        allowed = 1'b1;
    endcase
  end
  assign reqReady = allowed;
  // Track suspend state and resume-to-suspend spacing
  always_ff @(posedge link.clock)
  begin
    if (!rst_n)
    begin
      eraseSusp_r <= 1'b0;
      progSusp_r <= 1'b0;
      sector_r <= 16'h0000;
      eraseGap_r <= 32'h0000_0000;
      progGap_r <= 32'h0000_0000;
    end
    else
    begin
      if (eraseGap_r != 32'h0000_0000)
        eraseGap_r <= eraseGap_r - 32'h0000_0001;
      if (progGap_r != 32'h0000_0000)
        progGap_r <= progGap_r - 32'h0000_0001;
      if (reqValid && allowed)
      begin
        case (reqOpcode)
          `OP_ERASE:
            sector_r <= reqAddr[23:8];
          `OP_ERASE_SUSPEND:
            eraseSusp_r <= 1'b1; // RULE10
          `OP_PROG_SUSPEND:
            progSusp_r <= 1'b1; // RULE12
          `OP_ERASE_RESUME:
          begin
            eraseSusp_r <= 1'b0; // RULE11
            eraseGap_r <= 32'(`RESUME_GAP_CYC); // RULE2
          end
          `OP_PROG_RESUME:
          begin
            progSusp_r <= 1'b0; // RULE13
            progGap_r <= 32'(`RESUME_GAP_CYC); // RULE4
          end
          default:
            ;
        endcase
      end
    end
  end
  // Instruction issue and answer capture
  always_ff @(posedge link.clock)
  begin
    if (!rst_n)
    begin
      cmdValid_r <= 1'b0;
      cmdOpcode_r <= 8'h00;
      cmdAddr_r <= 24'h00_0000;
      rdData_r <= 32'h0000_0000;
      rdValid_r <= 1'b0;
    end
    else
    begin
      cmdValid_r <= reqValid && allowed;
      if (reqValid && allowed)
      begin
        cmdOpcode_r <= reqOpcode;
        cmdAddr_r <= reqAddr;
      end
      rdValid_r <= link.rspValid; // RULE15
      if (link.rspValid)
        rdData_r <= link.rspData;
    end
  end
  assign link.cmdValid = cmdValid_r;
  assign link.cmdOpcode = cmdOpcode_r;
  assign link.cmdAddr = cmdAddr_r;
  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
endmodule // flash_suspend_host

// ---- tb/suspend_checker.sv ----
// Link assertions for the suspend control
`timescale 1ns/10ps
`include "suspend_params.svh"
module suspend_checker
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire suspend_pkg::opcode_type cmdOpcode,
  input wire suspend_pkg::addr_type cmdAddr,
  input wire logic rspValid,
  input wire logic [31:0] rspData
);
  import suspend_pkg::*;
  logic eSusp_r;
  logic pSusp_r;
  logic [15:0] sect_r;
  int eGap_r;
  int pGap_r;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Operands pass as arguments so that assertions see sampled values
  function automatic logic is(input logic v, input opcode_type c, input opcode_type op);
    return v && c == op;
  endfunction
  // Suspend flags and cycles since each kind of resume
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      eSusp_r <= 1'b0;
      pSusp_r <= 1'b0;
      eGap_r <= `RESUME_GAP_CYC;
      pGap_r <= `RESUME_GAP_CYC;
    end
    else
    begin
      eSusp_r <= is(cmdValid, cmdOpcode, `OP_ERASE_SUSPEND) |
        (eSusp_r & !is(cmdValid, cmdOpcode, `OP_ERASE_RESUME));
      pSusp_r <= is(cmdValid, cmdOpcode, `OP_PROG_SUSPEND) |
        (pSusp_r & !is(cmdValid, cmdOpcode, `OP_PROG_RESUME));
      if (is(cmdValid, cmdOpcode, `OP_ERASE_RESUME))
        eGap_r <= 0;
      else if (eGap_r < `RESUME_GAP_CYC)
        eGap_r <= eGap_r + 1;
      if (is(cmdValid, cmdOpcode, `OP_PROG_RESUME))
        pGap_r <= 0;
      else if (pGap_r < `RESUME_GAP_CYC)
        pGap_r <= pGap_r + 1;
    end
  end
  // Sector of the last erase
  always_ff @(posedge clock)
    if (is(cmdValid, cmdOpcode, `OP_ERASE))
      sect_r <= cmdAddr[23:8];
  sequence resumeThenStatus;
    ((is(cmdValid, cmdOpcode, `OP_ERASE_RESUME) && eSusp_r) ||
      (is(cmdValid, cmdOpcode, `OP_PROG_RESUME) && pSusp_r))
      ##[1:3] is(cmdValid, cmdOpcode, `OP_READ_STATUS);
  endsequence
  chk_param_word:
    assert property (is(cmdValid, cmdOpcode, `OP_READ_PARAM) |->
      ##1 (rspValid && rspData == 32'h4418_83EC))
    else $error("param word");
  chk_status_form:
    assert property (is(cmdValid, cmdOpcode, `OP_READ_STATUS) |->
      ##1 (rspValid && rspData[31:1] == 31'h0))
    else $error("status form");
  chk_rsp_cause:
    assert property (rspValid |-> $past(cmdValid) &&
      ($past(cmdOpcode) inside {`OP_READ_STATUS, `OP_READ_PARAM}))
    else $error("stray answer");
  chk_no_erase_nest:
    assert property ((eSusp_r || pSusp_r) |-> !is(cmdValid, cmdOpcode, `OP_ERASE))
    else $error("nested erase");
  chk_no_prog_nest:
    assert property (pSusp_r |-> !is(cmdValid, cmdOpcode, `OP_PROG))
    else $error("nested program");
  chk_sector_guard:
    assert property (eSusp_r && (is(cmdValid, cmdOpcode, `OP_PROG) ||
      is(cmdValid, cmdOpcode, `OP_READ)) |-> cmdAddr[23:8] != sect_r)
    else $error("suspended sector");
  chk_erase_gap:
    assert property (is(cmdValid, cmdOpcode, `OP_ERASE_SUSPEND) |-> eGap_r >= `RESUME_GAP_CYC)
    else $error("erase suspend too soon");
  chk_prog_gap:
    assert property (is(cmdValid, cmdOpcode, `OP_PROG_SUSPEND) |-> pGap_r >= `RESUME_GAP_CYC)
    else $error("program suspend too soon");
  chk_resume_busy:
    assert property (resumeThenStatus |=> rspData[0])
    else $error("resume not busy");
endmodule // suspend_checker

// ---- tb/tb.sv ----
// Bench for host and device joined by the link
`timescale 1ns/10ps
`include "suspend_params.svh"
module tb;
  import suspend_pkg::*;
  logic clock = 0;
  logic rst_n = 0;
  logic reqValid = 0;
  opcode_type reqOpcode = '0;
  addr_type reqAddr = '0;
  logic reqReady;
  logic rdValid;
  logic [31:0] rdData;
  flash_state_type state;
  logic busy;
  int mismatches = 0;
  int cmp_count = 0;
  int n;
  always #50 clock = ~clock;
  suspend_if link (.clock(clock));
  flash_suspend_device #(.ERASE_CYC(200), .PROG_CYC(100)) flash_suspend_device_i
    (.link(link), .rst_n(rst_n), .state(state), .busy(busy));
  flash_suspend_host flash_suspend_host_i (.link(link), .rst_n(rst_n), .reqValid(reqValid),
    .reqOpcode(reqOpcode), .reqAddr(reqAddr), .reqReady(reqReady), .rdData(rdData),
    .rdValid(rdValid));
  suspend_checker suspend_checker_i (.clock(clock), .rst_n(rst_n), .cmdValid(link.cmdValid),
    .cmdOpcode(link.cmdOpcode), .cmdAddr(link.cmdAddr), .rspValid(link.rspValid),
    .rspData(link.rspData));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic req(input opcode_type op, input addr_type a);
    int k;
    @(negedge clock);
    reqValid = 1;
    reqOpcode = op;
    reqAddr = a;
    #1;
    for (k = 0; k < 50 && reqReady !== 1'b1; k++)
    begin
      @(negedge clock);
      #1;
    end
    check("taken", k < 50, 1);
    @(posedge clock);
    @(negedge clock);
    reqValid = 0;
  endtask
  task automatic rd(input opcode_type op, input logic [31:0] exp, input string name);
    int k;
    req(op, '0);
    for (k = 0; k < 5 && rdValid !== 1'b1; k++) @(negedge clock);
    check("rdValid", rdValid, 1);
    check(name, rdData, exp);
  endtask
  task automatic probe(input opcode_type op, input addr_type a, input logic exp);
    @(negedge clock);
    reqValid = 1;
    reqOpcode = op;
    reqAddr = a;
    #1 check("reqReady", reqReady, exp);
    @(negedge clock);
    reqValid = 0;
  endtask
  task automatic waitSt(input flash_state_type st);
    for (n = 0; n < 3000 && state !== st; n++) @(negedge clock);
  endtask
  initial
  begin
    repeat (4) @(negedge clock);
    rst_n = 1;
    rd(`OP_READ_PARAM, 32'h4418_83EC, "param");
    rd(`OP_READ_STATUS, 0, "idle");
    req(`OP_ERASE, 24'h00_1200);
    rd(`OP_READ_STATUS, 1, "erasing");
    req(8'h75, '0);
    waitSt(ST_ERASE_SUSP);
    check("esusp lat", n <= `SUSPEND_LAT_CYC, 1);
    rd(`OP_READ_STATUS, 0, "esusp");
    check("esusp busy", busy, 0);
    probe(`OP_ERASE, 24'h00_8000, 0);
    probe(`OP_PROG, 24'h00_1234, 0);
    probe(`OP_READ, 24'h00_12FF, 0);
    probe(`OP_READ, 24'h00_1300, 1);
    req(`OP_PROG, 24'h00_8000);
    repeat (110) @(negedge clock);
    check("nested prog", state, ST_ERASE_SUSP);
    repeat (5) @(negedge clock);
    req(8'h7A, '0);
    rd(`OP_READ_STATUS, 1, "eresume");
    check("eresume st", state, ST_ERASE);
    check("eresume busy", busy, 1);
    probe(8'h75, '0, 0);
    waitSt(ST_IDLE);
    rd(`OP_READ_STATUS, 0, "erase done");
    req(`OP_PROG, 24'h00_4000);
    req(8'h85, '0);
    waitSt(ST_PROG_SUSP);
    check("psusp lat", n <= `SUSPEND_LAT_CYC, 1);
    probe(`OP_PROG, 24'h00_9000, 0);
    probe(`OP_ERASE, 24'h00_9000, 0);
    req(8'h8A, '0);
    rd(`OP_READ_STATUS, 1, "presume");
    check("presume st", state, ST_PROG);
    probe(8'h85, '0, 0);
    repeat (1300) @(negedge clock);
    probe(8'h85, '0, 1);
    req(8'h7A, '0);
    repeat (25) @(negedge clock);
    check("ignored", state, ST_IDLE);
    final_report;
  end
  initial
  begin
    #2_000_000;
    mismatches++;
    final_report;
  end
endmodule // tb
